// [pkg/tws_pkg.sv]
// Purpose: Shared constants and types of the two-wire slave port and master.
// Assumes: A 200 MHz system clock on both ends.
// Notes: Pointers are 13 bits wide so one width serves every target.
package tws_pkg;
  localparam logic [6:0] RTC_SLAVE_ADDR = 7'h68;
  localparam logic [3:0] MEM_BLOCK_PREFIX = 4'hA;
  localparam logic [6:0] MEM_WIDE_ADDR = 7'h50;
  localparam int PTR_W = 13;
  localparam logic [12:0] PTR_RESET = 13'h0000;
  localparam logic [12:0] RTC_LAST = 13'h0012;
  localparam logic [12:0] MEM_SMALL_LAST = 13'h07FF;
  localparam logic [12:0] MEM_LARGE_LAST = 13'h1FFF;
  localparam logic BUS_IDLE = 1'b1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  localparam int SCL_QUARTER_FAST = SYS_CLK_HZ / (4 * SCL_FAST_HZ);
  localparam int SCL_QUARTER_STD = SYS_CLK_HZ / (4 * SCL_STD_HZ);
  localparam int SCL_QUARTER_MIN = 8;
  localparam int DIV_W = 16;

  typedef enum logic {TGT_RTC = 1'b0, TGT_MEM = 1'b1} tws_target_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_WR = 3'b010,
    S_RD = 3'b011, S_IGN = 3'b100
  } tws_slv_state_type;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_BIT = 3'b010,
    M_HOLD = 3'b011, M_STOP = 3'b100
  } tws_mst_state_type;

  typedef struct packed {
    tws_slv_state_type st;
    logic scl;
    logic sda;
    logic ack_seen;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic sda_oe;
    tws_target_type tgt;
    logic rw;
    logic [1:0] idx;
    logic [PTR_W-1:0] rtc_ptr;
    logic [PTR_W-1:0] mem_ptr;
    logic req_tgl;
    logic req_wr;
    tws_target_type req_tgt;
    logic [PTR_W-1:0] req_addr;
    logic [7:0] req_wdata;
    logic [7:0] rd_buf;
  } tws_link_type;

  typedef struct packed {
    logic req_seen;
    logic stb;
    logic wr;
    tws_target_type tgt;
    logic [PTR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack_tgl;
  } tws_sys_type;

  typedef struct packed {
    tws_mst_state_type st;
    logic [DIV_W-1:0] div;
    logic [1:0] q;
    logic [3:0] bit_n;
    logic [7:0] sh;
    logic rd;
    logic nack;
    logic stop;
    logic scl_oe;
    logic sda_oe;
    logic sda_f;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ack;
  } tws_mst_type;
endpackage : tws_pkg

// [pkg/tws_if.sv]
// Purpose: Open-drain two-wire bus joining the master and the slave port.
// Assumes: Each end pulls a line low only while its enable is high.
// Notes: A released line reads high, as with a pull-up resistor.
interface tws_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;

  assign scl = scl_oe_m ? scl_o_m : 1'b1;
  assign sda = (sda_oe_m ? sda_o_m : 1'b1) & (sda_oe_s ? sda_o_s : 1'b1);

  modport master (
    input scl, input sda,
    output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m
  );
  modport slave (
    input scl, input sda,
    output sda_o_s, output sda_oe_s
  );
endinterface : tws_if

// [src/tws_slave.sv]
// Purpose: Two-wire slave port for a clock/calendar with attached memory.
// Assumes: CLK_LINK oversamples the bus; user access runs on CLK_SYS.
// Notes: Register and memory contents live outside, behind the ACC port.

// Summary of operation
// R1: Slave only, standard and fast rates.
// R2: SDA fall with SCL high starts.
// R3: SDA rise with SCL high stops.
// R4: Data changes only while SCL low.
// R5: Master starts only on an idle bus.
// R6: Bytes go MSB first, then acknowledge.
// R7: Acknowledge holds SDA low through SCL high.
// R8: Master makes every clock, start, stop.
// R9: Slave releases SDA after master not-acknowledge.
// R10: Any number of bytes per transfer.
// R11: Clock registers answer address 1101000.
// R12: Small memory: prefix 1010, three block bits.
// R13: Large memory answers address 1010000 only.
// R14: Large memory takes two word-address bytes.
// R15: Direction bit zero writes, one reads.
// R16: Matching address byte is acknowledged.
// R17: Write loads pointer, stores, acknowledges bytes.
// R18: Read starts at the stored pointer.
// R19: Read continues until not-acknowledge.
// R20: Pointer-only write sets read start.
// R21: Repeated start begins a fresh address phase.
// R22: Pointer advances per byte and wraps.
// R23: Unmatched address: no acknowledge, ignore.
module tws_slave #(
  parameter bit MEM_LARGE = 1'b0
) (
  input logic CLK_SYS,
  input logic RST,
  input logic CLK_LINK,
  tws_if.slave BUS,
  output logic ACC_STB,
  output logic ACC_WRITE,
  output tws_pkg::tws_target_type ACC_TARGET,
  output logic [tws_pkg::PTR_W-1:0] ACC_ADDR,
  output logic [7:0] ACC_WDATA,
  input logic [7:0] ACC_RDATA
);
  import tws_pkg::*;

  localparam logic [PTR_W-1:0] MEM_LAST =
    MEM_LARGE ? MEM_LARGE_LAST : MEM_SMALL_LAST;

  tws_link_type r;
  tws_link_type next_r;
  tws_sys_type rs;
  tws_sys_type next_rs;
  logic [2:0] rst_sy;
  logic lrst;
  logic [2:0] lnk_s1;
  logic [2:0] lnk_s2;
  logic [2:0] lnk_s3;
  logic [2:0] lf;
  logic sys_s1;
  logic sys_s2;
  logic sys_s3;
  logic sys_f;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic do_req;
  logic req_wr;
  logic [1:0] hit;

  function automatic logic [PTR_W-1:0] step(
    input logic [PTR_W-1:0] p,
    input logic [PTR_W-1:0] last
  );
    step = (p == last) ? PTR_RESET : p + 1'b1;
  endfunction : step

  // Returns {match, target} for a received seven-bit address.
  function automatic logic [1:0] decode(input logic [6:0] a);
    if (a == RTC_SLAVE_ADDR) begin
      decode = {1'b1, TGT_RTC}; // R11
    end else if (MEM_LARGE && a == MEM_WIDE_ADDR) begin
      decode = {1'b1, TGT_MEM}; // R13
    end else if (!MEM_LARGE && a[6:3] == MEM_BLOCK_PREFIX) begin
      decode = {1'b1, TGT_MEM}; // R12
    end else begin
      decode = 2'b00;
    end
  endfunction : decode

  // Reset and bus pins enter the link domain through three flops.
  always_ff @(posedge CLK_LINK) begin
    rst_sy <= {rst_sy[1:0], RST};
    if (rst_sy[1] == rst_sy[2]) begin
      lrst <= rst_sy[2];
    end
    lnk_s1 <= {BUS.scl, BUS.sda, rs.ack_tgl}; // R1
    lnk_s2 <= lnk_s1;
    lnk_s3 <= lnk_s2;
  end

  // A high level only counts once two samples agree, which rejects one-sample high glitches; disagreeing samples read low, two low samples hold the old level.
  assign lf = (lnk_s2 & lnk_s3)
            | ({r.scl, r.sda, r.ack_seen} & ~(lnk_s2 ^ lnk_s3));

  always_comb begin
    next_r = r;
    do_req = 1'b0;
    req_wr = 1'b0;
    hit = decode(r.sh[7:1]);
    next_r.scl = lf[2];
    next_r.sda = lf[1];
    next_r.ack_seen = lf[0];
    rise = lf[2] & ~r.scl;
    fall = ~lf[2] & r.scl;
    start = lf[2] & r.scl & r.sda & ~lf[1]; // R2
    stop = lf[2] & r.scl & ~r.sda & lf[1]; // R3
    if (lf[0] != r.ack_seen) begin
      next_r.rd_buf = rs.rdata;
    end
    if (start) begin
      next_r.st = S_ADDR; // R21
      // The SCL fall that closes START wraps this count to zero.
      next_r.cnt = 4'hF;
      next_r.idx = 2'b00;
      next_r.sda_oe = 1'b0;
    end else if (stop) begin
      next_r.st = S_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (r.st != S_IDLE && r.st != S_IGN) begin
      if (rise) begin
        if (r.cnt != BIT_ACK && r.st != S_RD) begin
          next_r.sh = {r.sh[6:0], lf[1]}; // R6
        end else if (r.cnt == BIT_ACK && r.st == S_RD) begin
          if (lf[1]) begin
            next_r.st = S_IGN; // R19
          end else begin
            do_req = 1'b1;
          end
        end
      end else if (fall) begin
        if (r.cnt == BIT_LAST) begin
          next_r.cnt = BIT_ACK;
          case (r.st)
            S_ADDR: begin
              if (hit[1]) begin
                next_r.tgt = tws_target_type'(hit[0]);
                next_r.rw = r.sh[0]; // R15
                next_r.sda_oe = 1'b1; // R16
                if (!MEM_LARGE && hit[0]) begin
                  next_r.mem_ptr[10:8] = r.sh[3:1]; // R12
                end
                do_req = r.sh[0]; // R18
              end else begin
                next_r.st = S_IGN; // R23
              end
            end
            S_WR: begin
              next_r.sda_oe = 1'b1; // R17
              if (r.idx == 2'b00) begin
                if (r.tgt == TGT_RTC) begin
                  next_r.rtc_ptr = {5'h00, r.sh}; // R17
                  next_r.idx = 2'b10;
                end else if (MEM_LARGE) begin
                  next_r.mem_ptr[12:8] = r.sh[4:0]; // R14
                  next_r.idx = 2'b01;
                end else begin
                  next_r.mem_ptr[7:0] = r.sh;
                  next_r.idx = 2'b10;
                end
              end else if (r.idx == 2'b01) begin
                next_r.mem_ptr[7:0] = r.sh; // R14
                next_r.idx = 2'b10;
              end else begin
                do_req = 1'b1; // R10
                req_wr = 1'b1;
              end
            end
            default: begin
              next_r.sda_oe = 1'b0; // R9
            end
          endcase
        end else if (r.cnt == BIT_ACK) begin
          next_r.cnt = 4'h0;
          if (r.st == S_RD || (r.st == S_ADDR && r.rw)) begin
            next_r.st = S_RD;
            next_r.sh = r.rd_buf;
            next_r.sda_oe = ~r.rd_buf[7]; // R4
          end else begin
            next_r.st = S_WR;
            next_r.sda_oe = 1'b0; // R7
          end
        end else begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.st == S_RD) begin
            next_r.sh = {r.sh[6:0], 1'b0};
            next_r.sda_oe = ~r.sh[6]; // R4
          end
        end
      end
    end
    // Each access hands one word to the system side and moves the pointer.
    if (do_req) begin
      next_r.req_tgl = ~r.req_tgl;
      next_r.req_wr = req_wr;
      next_r.req_tgt = next_r.tgt;
      next_r.req_wdata = r.sh;
      if (next_r.tgt == TGT_RTC) begin
        next_r.req_addr = next_r.rtc_ptr;
        next_r.rtc_ptr = step(next_r.rtc_ptr, RTC_LAST); // R22
      end else begin
        next_r.req_addr = next_r.mem_ptr;
        next_r.mem_ptr = step(next_r.mem_ptr, MEM_LAST); // R22
      end
    end
  end

  always_ff @(posedge CLK_LINK) begin
    if (lrst) begin
      r <= '0;
      r.scl <= BUS_IDLE;
      r.sda <= BUS_IDLE;
      r.rtc_ptr <= PTR_RESET;
      r.mem_ptr <= PTR_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign BUS.sda_o_s = 1'b0;
  assign BUS.sda_oe_s = r.sda_oe;

  // The request toggle crosses to CLK_SYS; its payload is held stable.
  always_ff @(posedge CLK_SYS) begin
    sys_s1 <= r.req_tgl;
    sys_s2 <= sys_s1;
    sys_s3 <= sys_s2;
  end

  assign sys_f = (sys_s2 & sys_s3) | (rs.req_seen & ~(sys_s2 ^ sys_s3));

  always_comb begin
    next_rs = rs;
    next_rs.stb = 1'b0;
    next_rs.req_seen = sys_f;
    if (sys_f != rs.req_seen) begin
      next_rs.stb = 1'b1;
      next_rs.wr = r.req_wr;
      next_rs.tgt = r.req_tgt;
      next_rs.addr = r.req_addr;
      next_rs.wdata = r.req_wdata;
    end
    if (rs.stb) begin
      if (!rs.wr) begin
        next_rs.rdata = ACC_RDATA;
      end
      next_rs.ack_tgl = ~rs.ack_tgl;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end

  assign ACC_STB = rs.stb;
  assign ACC_WRITE = rs.wr;
  assign ACC_TARGET = rs.tgt;
  assign ACC_ADDR = rs.addr;
  assign ACC_WDATA = rs.wdata;
endmodule : tws_slave

// [src/tws_master.sv]
// Purpose: Two-wire bus master that drives SCL from a divided CLK_SYS.
// Assumes: A single master and a slave that never stretches the clock.
// Notes: One command moves one byte plus its acknowledge bit.
module tws_master #(
  parameter int QUARTER = tws_pkg::SCL_QUARTER_FAST
) (
  input logic CLK_SYS,
  input logic RST,
  tws_if.master BUS,
  input logic CMD_VALID,
  output logic CMD_READY,
  input logic CMD_START,
  input logic CMD_STOP,
  input logic CMD_READ,
  input logic CMD_NACK,
  input logic [7:0] CMD_WDATA,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ACK
);
  import tws_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(QUARTER - 1);

  generate
    if (QUARTER < SCL_QUARTER_MIN || QUARTER > (1 << DIV_W)) begin : g_chk
      $error("QUARTER out of range for the SCL divider.");
    end
  endgenerate

  tws_mst_type r;
  tws_mst_type next_r;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic tick;
  logic waiting;

  always_ff @(posedge CLK_SYS) begin
    sda_s1 <= BUS.sda;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
  end

  assign waiting = (r.st == M_IDLE) || (r.st == M_HOLD);
  assign CMD_READY = waiting;
  assign tick = (r.div == '0);

  // Each bit spans four quarters: data, SCL up, sample, SCL down.
  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.sda_f = (sda_s2 & sda_s3) | (r.sda_f & ~(sda_s2 ^ sda_s3));
    if (waiting || tick) begin
      next_r.div = DIV_LOAD;
    end else begin
      next_r.div = r.div - 1'b1;
    end
    case (r.st)
      M_IDLE, M_HOLD: begin
        if (CMD_VALID) begin
          next_r.sh = CMD_WDATA;
          next_r.rd = CMD_READ;
          next_r.nack = CMD_NACK;
          next_r.stop = CMD_STOP;
          next_r.bit_n = 4'h0;
          next_r.q = 2'b00;
          if (CMD_START || r.st == M_IDLE) begin
            next_r.st = M_START; // R5
          end else begin
            next_r.st = M_BIT;
          end
        end
      end
      M_START: begin
        if (tick) begin
          next_r.q = r.q + 2'b01;
          case (r.q)
            2'b00: next_r.sda_oe = 1'b0;
            2'b01: next_r.scl_oe = 1'b0;
            2'b10: next_r.sda_oe = 1'b1; // R2
            default: begin
              next_r.scl_oe = 1'b1; // R8
              next_r.st = M_BIT;
            end
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          next_r.q = r.q + 2'b01;
          case (r.q)
            2'b00: begin
              if (r.bit_n != BIT_ACK) begin
                next_r.sda_oe = ~r.rd & ~r.sh[7]; // R4
              end else begin
                next_r.sda_oe = r.rd & ~r.nack; // R9
              end
            end
            2'b01: next_r.scl_oe = 1'b0; // R7
            2'b10: begin
              if (r.bit_n != BIT_ACK) begin
                next_r.sh = {r.sh[6:0], r.sda_f}; // R6
              end else begin
                next_r.rsp_ack = ~r.sda_f;
              end
            end
            default: begin
              next_r.scl_oe = 1'b1; // R8
              if (r.bit_n == BIT_ACK) begin
                next_r.rsp_valid = 1'b1;
                next_r.rsp_data = r.sh;
                next_r.st = r.stop ? M_STOP : M_HOLD; // R10
              end else begin
                next_r.bit_n = r.bit_n + 4'h1;
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          next_r.q = r.q + 2'b01;
          case (r.q)
            2'b00: next_r.sda_oe = 1'b1;
            2'b01: next_r.scl_oe = 1'b0;
            2'b10: next_r.sda_oe = 1'b0; // R3
            default: next_r.st = M_IDLE;
          endcase
        end
      end
      default: begin
        next_r.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      r <= '0;
      r.div <= DIV_LOAD;
      r.sda_f <= BUS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign BUS.scl_o_m = 1'b0;
  assign BUS.scl_oe_m = r.scl_oe;
  assign BUS.sda_o_m = 1'b0;
  assign BUS.sda_oe_m = r.sda_oe;
  assign RSP_VALID = r.rsp_valid;
  assign RSP_DATA = r.rsp_data;
  assign RSP_ACK = r.rsp_ack;
endmodule : tws_master

// [tb/tws_assertions.sv]
// Purpose: Wire checks on the bus joining master and slave port.
// Assumes: Bus lines move slowly against CLK_SYS, which samples them.
// Notes: ph counts bits of a frame; 8 marks the acknowledge slot.
module tws_assertions
  import tws_pkg::*;
(
  input logic CLK_SYS,
  input logic RST,
  input logic scl,
  input logic sda,
  input logic scl_oe_m,
  input logic sda_oe_s
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_d, sda_d, first, quiet, hit;
  logic [3:0] ph;
  logic [7:0] sh;

  assign hit = sh[7:1] == RTC_SLAVE_ADDR || sh[7:4] == MEM_BLOCK_PREFIX;
  always_ff @(posedge CLK_SYS) begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && !scl_d) begin
      sh <= {sh[6:0], sda};
    end
  end
  // Only a high acknowledge slot silences the slave until the next START.
  always_ff @(posedge CLK_SYS) begin
    if (RST || (scl && scl_d && sda_d && !sda)) begin
      ph <= 4'hF;
      first <= !RST;
      quiet <= 1'b0;
    end else if (scl_d && !scl) begin
      ph <= (ph == 4'h8) ? 4'h0 : ph + 4'h1;
      first <= first && ph != 4'h8;
    end else if (scl && !scl_d && ph == 4'h8 && sda) begin
      quiet <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_slot;
    $rose(scl) && ph == 4'h8 && first;
  endsequence
  sequence s_ack_hi;
    $rose(scl) && ph == 4'h8 && sda_oe_s;
  endsequence

  property p_data_stable;
    scl && $past(scl) |-> $stable(sda_oe_s);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("slave moved SDA while SCL high");
  property p_start_low;
    s_start |-> ##[1:40] !scl;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("SCL not lowered after START");
  property p_stop_idle;
    s_stop |-> (!sda_oe_s && !scl_oe_m) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus driven after STOP");
  property p_ack_holds;
    s_ack_hi |-> !sda throughout (##[1:60] $fell(scl));
  endproperty
  a_ack_holds: assert property (p_ack_holds)
    else $error("acknowledge not held low");
  property p_addr_quiet;
    first && ph < 4'h8 |-> !sda_oe_s;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("slave drove SDA in address byte");
  property p_match_ack;
    s_slot ##0 hit |-> !sda;
  endproperty
  a_match_ack: assert property (p_match_ack)
    else $error("matching address not acknowledged");
  property p_miss_free;
    s_slot ##0 !hit |-> sda;
  endproperty
  a_miss_free: assert property (p_miss_free)
    else $error("foreign address acknowledged");
  property p_nack_quiet;
    quiet |-> !sda_oe_s;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet)
    else $error("slave drove SDA after a high slot");
endmodule : tws_assertions

// [tb/tb_two_wire_slave_port.sv]
// Purpose: Self-checking bench for the two-wire master and slave port.
// Assumes: Bench memory answers slave accesses with zero wait.
// Notes: Block-select memory only; a short QUARTER keeps runs brief.
module tb_two_wire_slave_port;
  timeunit 1ns;
  timeprecision 100ps;
  import tws_pkg::*;
  logic CLK_SYS = 1'b0;
  logic CLK_LINK = 1'b0;
  logic RST = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_nack = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_ack, acc_stb, acc_write, got_a;
  logic [7:0] rsp_data, acc_wdata, acc_rdata, got_q;
  logic [12:0] acc_addr;
  tws_target_type acc_target;
  logic [7:0] ram [2][8192];
  logic [21:0] exq [$];
  int ptr [2];
  int num_errors = 0;
  int n_compared = 0;

  always #2.5 CLK_SYS = ~CLK_SYS;
  always #3 CLK_LINK = ~CLK_LINK;
  assign acc_rdata = ram[acc_target][acc_addr];

  tws_if bus ();
  tws_master #(.QUARTER(16)) u_tws_master (
    .CLK_SYS(CLK_SYS), .RST(RST), .BUS(bus), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_START(cmd_start), .CMD_STOP(cmd_stop),
    .CMD_READ(cmd_read), .CMD_NACK(cmd_nack), .CMD_WDATA(cmd_wdata),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ACK(rsp_ack)
  );
  tws_slave #(.MEM_LARGE(1'b0)) u_tws_slave (
    .CLK_SYS(CLK_SYS), .RST(RST), .CLK_LINK(CLK_LINK), .BUS(bus),
    .ACC_STB(acc_stb), .ACC_WRITE(acc_write), .ACC_TARGET(acc_target),
    .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_RDATA(acc_rdata)
  );
  tws_assertions u_tws_assertions (
    .CLK_SYS(CLK_SYS), .RST(RST), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_m(bus.scl_oe_m), .sda_oe_s(bus.sda_oe_s)
  );

  task automatic cmp(input logic [23:0] g, e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_ack(input logic g, e);
    cmp({23'h0, g}, {23'h0, e});
  endtask : cmp_ack
  task automatic cmp_data(input logic [7:0] g, e);
    cmp({16'h0, g}, {16'h0, e});
  endtask : cmp_data
  task automatic cmp_acc(input logic [21:0] g, e);
    cmp({2'h0, g}, {2'h0, e});
  endtask : cmp_acc

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Every write strobe must be one the model expects, in order.
  always @(negedge CLK_SYS) begin
    if (acc_stb === 1'b1 && acc_write === 1'b1) begin
      ram[acc_target][acc_addr] = acc_wdata;
      if (exq.size() == 0) exq.push_back(22'h3FFFFF);
      cmp_acc({acc_target, acc_addr, acc_wdata}, exq.pop_front());
    end
  end

  task automatic cmd(input logic s, p, r, n, input logic [7:0] d);
    int k;
    cmd_valid <= 1'b1;
    cmd_start <= s;
    cmd_stop <= p;
    cmd_read <= r;
    cmd_nack <= n;
    cmd_wdata <= d;
    k = 0;
    // Outputs are read at the falling edge, well away from their launch.
    @(negedge CLK_SYS);
    while (cmd_ready !== 1'b1 && k < 3000) begin
      k++;
      @(negedge CLK_SYS);
    end
    @(posedge CLK_SYS);
    cmd_valid <= 1'b0;
    @(negedge CLK_SYS);
    while (rsp_valid !== 1'b1 && k < 6000) begin
      k++;
      @(negedge CLK_SYS);
    end
    got_q = rsp_data;
    got_a = rsp_ack;
    @(posedge CLK_SYS);
    if (k >= 6000) begin
      num_errors++;
      complete_run();
    end
  endtask : cmd

  task automatic put(input logic s, p, input logic [7:0] d, input logic e);
    cmd(s, p, 1'b0, 1'b0, d);
    cmp_ack(got_a, e);
  endtask : put

  function automatic int nxt(input int t);
    if (t == 0) return (ptr[0] == RTC_LAST) ? 0 : ptr[0] + 1;
    return (ptr[1] + 1) % (MEM_SMALL_LAST + 1);
  endfunction : nxt

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
                    input logic stp);
    int t;
    logic hit;
    logic [7:0] d;
    hit = a == RTC_SLAVE_ADDR || a[6:3] == MEM_BLOCK_PREFIX;
    t = a != RTC_SLAVE_ADDR;
    put(1'b1, !hit, {a, 1'b0}, hit);
    if (!hit) return;
    put(1'b0, stp && n == 0, p, 1'b1);
    ptr[t] = t ? {a[2:0], p} : p;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      exq.push_back({t[0], ptr[t][12:0], d});
      put(1'b0, stp && i == n - 1, d, 1'b1);
      ptr[t] = nxt(t);
    end
  endtask : wr

  task automatic rd(input logic [6:0] a, input int n);
    int t;
    t = a != RTC_SLAVE_ADDR;
    put(1'b1, 1'b0, {a, 1'b1}, 1'b1);
    if (t) ptr[1] = {a[2:0], ptr[1][7:0]};
    for (int i = 0; i < n; i++) begin
      cmd(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00);
      cmp_data(got_q, ram[t][ptr[t]]);
      ptr[t] = nxt(t);
    end
  endtask : rd

  initial begin
    logic [6:0] a;
    void'($urandom(44502));
    foreach (ram[i, j]) ram[i][j] = 8'($urandom);
    // The link side needs reset across several of its own edges.
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (20) @(posedge CLK_SYS);
    wr(RTC_SLAVE_ADDR, 8'h11, 3, 1'b1);
    wr(RTC_SLAVE_ADDR, 8'h11, 0, 1'b0);
    rd(RTC_SLAVE_ADDR, 3);
    rd(RTC_SLAVE_ADDR, 1);
    wr(7'h33, 8'h00, 1, 1'b1);
    wr(7'h57, 8'hFE, 3, 1'b1);
    wr(7'h57, 8'hFE, 0, 1'b0);
    rd(7'h57, 3);
    rd(7'h52, 2);
    repeat (6) begin
      a = $urandom_range(1) ? RTC_SLAVE_ADDR : {MEM_BLOCK_PREFIX, 3'($urandom)};
      wr(a, 8'($urandom_range(18)), $urandom_range(3), 1'b1);
      rd(a, 1 + $urandom_range(2));
    end
    cmp_acc(22'(exq.size()), 22'h0);
    complete_run();
  end
endmodule : tb_two_wire_slave_port
